// ==== src/ofd_pkg.sv ====
// ----------------------------------------------------------------------------
// Shared constants and carriers of the operand field decoder.
// ----------------------------------------------------------------------------
package ofd_pkg;

  // Opcode of the register-to-register add.
  localparam logic [7:0]  OFD_OPC_ADD  = 8'h04;
  // Upper nibble that marks an escaped working-register code.
  localparam logic [3:0]  OFD_ESC_NIB  = 4'hE;
  localparam logic [3:0]  OFD_ZERO_NIB = 4'h0;
  localparam logic [7:0]  OFD_ZERO_B   = 8'h00;
  localparam logic [11:0] OFD_ZERO_A   = 12'h000;
  localparam logic [15:0] OFD_ZERO_W   = 16'h0000;
  localparam logic [12:0] OFD_ZERO_13  = 13'h0000;
  localparam logic [14:0] OFD_ZERO_15  = 15'h0000;
  localparam logic [11:0] OFD_ZERO_12  = 12'h000;
  localparam logic [7:0]  OFD_ZERO_8   = 8'h00;

  // Operand field kinds that the field port decodes.
  typedef enum logic [3:0] {
    OFD_K_REG8,
    OFD_K_BIT,
    OFD_K_POL,
    OFD_K_LIT,
    OFD_K_VEC,
    OFD_K_IND,
    OFD_K_EXT12,
    OFD_K_DIRECT,
    OFD_K_WPAIR,
    OFD_K_RPAIR,
    OFD_K_REL,
    OFD_K_IDX
  } ofd_kind_t;

  // Field decode request: kind, first and second operand byte, next address.
  typedef struct packed {
    logic        valid;
    ofd_kind_t   kind;
    logic [7:0]  b0;
    logic [7:0]  b1;
    logic [15:0] next_pc;
  } ofd_fld_req_t;

  // Field decode answer.
  typedef struct packed {
    logic        valid;
    logic        err;
    logic        working;
    logic [15:0] value;
  } ofd_fld_res_t;

  // Register file access issued by the add sequencer.
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } ofd_rf_req_t;

endpackage

// ==== src/ofd_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none

module ofd_decoder (
  input  wire logic                  I_CLK,
  input  wire logic                  I_RST,
  input  wire logic [7:0]            i_rp,
  input  wire logic                  i_ins_valid,
  input  wire logic [7:0]            i_ins_byte,
  output logic                       o_ins_ready,
  output ofd_pkg::ofd_rf_req_t       o_rf,
  input  wire logic [7:0]            i_rf_rdata,
  output logic                       o_add_done,
  output logic                       o_add_carry,
  input  wire ofd_pkg::ofd_fld_req_t i_fld,
  output ofd_pkg::ofd_fld_res_t      o_fld
);

  // --------------------------------------------------------------------------
  // Register mapping shared by the field port and the add sequencer; sign extension for the field port
  // --------------------------------------------------------------------------

  // An escaped code is a working register, placed in the window that the
  // register pointer selects; any other byte is a plain file address.
  function automatic logic [11:0] map_reg8(input logic [7:0] b, input logic [7:0] rp);
    logic [11:0] a;
    a = {ofd_pkg::OFD_ZERO_NIB, b};
    if (b[7:4] == ofd_pkg::OFD_ESC_NIB) begin
      a = {rp, b[3:0]};
    end
    return a;
  endfunction

  function automatic logic [15:0] sext8(input logic [7:0] b);
    return {{8{b[7]}}, b};
  endfunction

  // --------------------------------------------------------------------------
  // Add sequencer
  // --------------------------------------------------------------------------

  typedef enum logic [2:0] {S_IDLE, S_SRC, S_DST, S_RD_SRC, S_RD_DST, S_WRITE, S_DONE} ofd_state_t;

  ofd_state_t  state_q;
  logic [11:0] src_a_q;
  logic [11:0] dst_a_q;
  logic [7:0]  src_v_q;
  ofd_pkg::ofd_rf_req_t rf_q;
  logic        done_q;
  logic        carry_q;
  logic [8:0]  sum;

  assign o_ins_ready = (state_q == S_IDLE) || (state_q == S_SRC) || (state_q == S_DST);
  assign o_rf        = rf_q;
  assign o_add_done  = done_q;
  assign o_add_carry = carry_q;
  assign sum         = {1'b0, i_rf_rdata} + {1'b0, src_v_q};

  // Walk through opcode, source byte, destination byte, two reads and a write.
  // Opcodes other than the add are consumed and dropped; the full map lives
  // elsewhere.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_q <= S_IDLE;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (i_ins_valid && i_ins_byte == ofd_pkg::OFD_OPC_ADD) begin
            state_q <= S_SRC;
          end
        end
        S_SRC: begin
          if (i_ins_valid) begin
            state_q <= S_DST;
          end
        end
        S_DST: begin
          if (i_ins_valid) begin
            state_q <= S_RD_SRC;
          end
        end
        S_RD_SRC: state_q <= S_RD_DST;
        S_RD_DST: state_q <= S_WRITE;
        S_WRITE:  state_q <= S_DONE;
        S_DONE:   state_q <= S_IDLE;
        default:  state_q <= S_IDLE;
      endcase
    end
  end

  // Capture the operand addresses; the source byte comes first.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      src_a_q <= ofd_pkg::OFD_ZERO_A;
      dst_a_q <= ofd_pkg::OFD_ZERO_A;
    end else begin
      if (state_q == S_SRC && i_ins_valid) begin
        src_a_q <= map_reg8(i_ins_byte, i_rp);
      end
      if (state_q == S_DST && i_ins_valid) begin
        dst_a_q <= map_reg8(i_ins_byte, i_rp);
      end
    end
  end

  // Register file strobes are registered, so read data for a strobe seen in
  // one cycle arrives in the next; that fixes when each value is captured.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rf_q    <= '0;
      src_v_q <= ofd_pkg::OFD_ZERO_B;
      carry_q <= 1'b0;
    end else begin
      rf_q.rd <= 1'b0;
      rf_q.wr <= 1'b0;
      case (state_q)
        S_DST: begin
          if (i_ins_valid) begin
            rf_q.rd   <= 1'b1;
            rf_q.addr <= src_a_q;
          end
        end
        S_RD_SRC: begin
          rf_q.rd   <= 1'b1;
          rf_q.addr <= dst_a_q;
        end
        S_RD_DST: begin
          src_v_q <= i_rf_rdata;
        end
        S_WRITE: begin
          rf_q.wr    <= 1'b1;
          rf_q.addr  <= dst_a_q;
          rf_q.wdata <= sum[7:0];
          carry_q    <= sum[8];
        end
        default: begin
          rf_q.rd <= 1'b0;
        end
      endcase
    end
  end

  // One-cycle completion pulse, in step with the write strobe.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (state_q == S_WRITE);
    end
  end

  // --------------------------------------------------------------------------
  // Operand field port
  // --------------------------------------------------------------------------

  ofd_pkg::ofd_fld_res_t fld_d;
  ofd_pkg::ofd_fld_res_t fld_q;

  // Odd pair indices are rounded down to even and also flagged, so a bad encoding is seen.
  always_comb begin
    fld_d       = '0;
    fld_d.valid = i_fld.valid;
    case (i_fld.kind)
      ofd_pkg::OFD_K_REG8: begin
        fld_d.value   = {ofd_pkg::OFD_ZERO_NIB, map_reg8(i_fld.b0, i_rp)};
        fld_d.working = (i_fld.b0[7:4] == ofd_pkg::OFD_ESC_NIB);
      end
      ofd_pkg::OFD_K_BIT:    fld_d.value = {ofd_pkg::OFD_ZERO_13, i_fld.b0[2:0]};
      ofd_pkg::OFD_K_POL:    fld_d.value = {ofd_pkg::OFD_ZERO_15, i_fld.b0[0]};
      ofd_pkg::OFD_K_LIT:    fld_d.value = {ofd_pkg::OFD_ZERO_8, i_fld.b0};
      ofd_pkg::OFD_K_VEC:    fld_d.value = {ofd_pkg::OFD_ZERO_8, i_fld.b0};
      ofd_pkg::OFD_K_IND:    fld_d.value = {ofd_pkg::OFD_ZERO_8, i_fld.b0};
      ofd_pkg::OFD_K_EXT12:  fld_d.value = {ofd_pkg::OFD_ZERO_NIB, i_fld.b0[3:0], i_fld.b1};
      ofd_pkg::OFD_K_DIRECT: fld_d.value = {i_fld.b0, i_fld.b1};
      ofd_pkg::OFD_K_WPAIR: begin
        fld_d.value   = {ofd_pkg::OFD_ZERO_12, i_fld.b0[3:1], 1'b0};
        fld_d.err     = i_fld.b0[0];
        fld_d.working = 1'b1;
      end
      ofd_pkg::OFD_K_RPAIR: begin
        fld_d.value = {ofd_pkg::OFD_ZERO_8, i_fld.b0[7:1], 1'b0};
        fld_d.err   = i_fld.b0[0];
      end
      ofd_pkg::OFD_K_REL:    fld_d.value = i_fld.next_pc + sext8(i_fld.b0);
      ofd_pkg::OFD_K_IDX:    fld_d.value = {ofd_pkg::OFD_ZERO_8, i_fld.b1} + sext8(i_fld.b0);
      default:               fld_d.err   = 1'b1;
    endcase
  end

  // Answer is registered one cycle after the request.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      fld_q <= '0;
    end else begin
      fld_q <= fld_d;
    end
  end

  assign o_fld = fld_q;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------

  // The first byte taken after the opcode is the source; the state test pins
  // the match to that byte, so gaps of up to eight idle cycles are covered.
  sequence seq_add_bytes;
    i_ins_valid && o_ins_ready && i_ins_byte == ofd_pkg::OFD_OPC_ADD && state_q == S_IDLE
      ##[1:9] (i_ins_valid && state_q == S_SRC);
  endsequence

  a_add_src_read: assert property (@(posedge I_CLK) disable iff (I_RST)
    (state_q == S_DST && i_ins_valid) |=> o_rf.rd && o_rf.addr == src_a_q)
    else $error("Source read not issued after destination byte.");

  a_order_src_first: assert property (@(posedge I_CLK) disable iff (I_RST)
    seq_add_bytes |=> state_q == S_DST && src_a_q == map_reg8($past(i_ins_byte), $past(i_rp)))
    else $error("Source byte not taken first.");

  a_escape_map: assert property (@(posedge I_CLK) disable iff (I_RST)
    (i_fld.valid && i_fld.kind == ofd_pkg::OFD_K_REG8 && i_fld.b0[7:4] == ofd_pkg::OFD_ESC_NIB)
      |=> o_fld.working && o_fld.value[3:0] == $past(i_fld.b0[3:0]))
    else $error("Escaped code not mapped to working register.");

  a_pointer_join: assert property (@(posedge I_CLK) disable iff (I_RST)
    (i_fld.valid && i_fld.kind == ofd_pkg::OFD_K_REG8 && i_fld.b0[7:4] == ofd_pkg::OFD_ESC_NIB)
      |=> o_fld.value[11:4] == $past(i_rp))
    else $error("Register pointer not joined.");

  a_bit_range: assert property (@(posedge I_CLK) disable iff (I_RST)
    (i_fld.valid && i_fld.kind == ofd_pkg::OFD_K_BIT) |=> o_fld.value[15:3] == ofd_pkg::OFD_ZERO_13)
    else $error("Bit index wider than three bits.");

  a_direct_word: assert property (@(posedge I_CLK) disable iff (I_RST)
    (i_fld.valid && i_fld.kind == ofd_pkg::OFD_K_DIRECT) |=> o_fld.value == $past({i_fld.b0, i_fld.b1}))
    else $error("Direct address mismatch.");

  a_ext_range: assert property (@(posedge I_CLK) disable iff (I_RST)
    (i_fld.valid && i_fld.kind == ofd_pkg::OFD_K_EXT12) |=> o_fld.value[15:12] == ofd_pkg::OFD_ZERO_NIB)
    else $error("Extended address beyond twelve bits.");

  a_pair_even: assert property (@(posedge I_CLK) disable iff (I_RST)
    (i_fld.valid && i_fld.kind == ofd_pkg::OFD_K_RPAIR) |=> !o_fld.value[0] && o_fld.err == $past(i_fld.b0[0]))
    else $error("Register pair not even.");

  a_rel_target: assert property (@(posedge I_CLK) disable iff (I_RST)
    (i_fld.valid && i_fld.kind == ofd_pkg::OFD_K_REL)
      |=> o_fld.value == $past(i_fld.next_pc) + sext8($past(i_fld.b0)))
    else $error("Relative target wrong.");

  a_sum_write: assert property (@(posedge I_CLK) disable iff (I_RST)
    (state_q == S_WRITE) |=> o_rf.wr && o_add_done && o_rf.addr == dst_a_q
      && o_rf.wdata == $past(sum[7:0]) ##1 !o_rf.wr)
    else $error("Sum not written to destination.");

endmodule

`default_nettype wire

// ==== dv/ofd_rf_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Register file model on the far side of the add sequencer.
// ----------------------------------------------------------------------------
module ofd_rf_model (
  input  wire logic                 i_clk,
  input  wire ofd_pkg::ofd_rf_req_t i_rf,
  output logic [7:0]                o_rdata
);
  logic [7:0] mem [4096];

  // Every location starts from its own address pattern, so a wrong address shows.
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'(i) ^ {4'(i >> 8), 4'h0};
    end
  end

  // Read data is valid only in the cycle after the read; an idle bus shows the
  // inverse of the last byte, so sampling in the wrong cycle gives a wrong sum.
  always @(posedge i_clk) begin
    if (i_rf.rd) begin
      o_rdata <= mem[i_rf.addr];
    end else begin
      o_rdata <= ~o_rdata;
    end
    if (i_rf.wr) begin
      mem[i_rf.addr] <= i_rf.wdata;
    end
  end
endmodule

`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Self-checking bench of the operand field decoder.
// ----------------------------------------------------------------------------
module testbench;
  logic                  I_CLK = 1'b0;
  logic                  I_RST = 1'b1;
  logic [7:0]            i_rp = 8'h12;
  logic                  i_ins_valid = 1'b0;
  logic [7:0]            i_ins_byte = 8'h00;
  logic                  o_ins_ready;
  ofd_pkg::ofd_rf_req_t  o_rf;
  logic [7:0]            rf_rdata;
  logic                  o_add_done;
  logic                  o_add_carry;
  ofd_pkg::ofd_fld_req_t i_fld = '0;
  ofd_pkg::ofd_fld_res_t o_fld;
  int                    miscompares = 0;
  int                    tests_run = 0;

  ofd_decoder dut (.I_CLK(I_CLK), .I_RST(I_RST), .i_rp(i_rp), .i_ins_valid(i_ins_valid),
    .i_ins_byte(i_ins_byte), .o_ins_ready(o_ins_ready), .o_rf(o_rf), .i_rf_rdata(rf_rdata),
    .o_add_done(o_add_done), .o_add_carry(o_add_carry), .i_fld(i_fld), .o_fld(o_fld));
  ofd_rf_model pm (.i_clk(I_CLK), .i_rf(o_rf), .o_rdata(rf_rdata));

  always #20 I_CLK = ~I_CLK;

  // ----------------------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Escaped codes join the register pointer; plain bytes sit in the lowest page.
  function automatic logic [11:0] map(input logic [7:0] b);
    return (b[7:4] == 4'hE) ? {i_rp, b[3:0]} : {4'h0, b};
  endfunction

  // A byte is held until an edge that sees ready high, never longer than the bound.
  task automatic send(input logic [7:0] b);
    @(negedge I_CLK);
    i_ins_valid = 1'b1;
    i_ins_byte = b;
    for (int n = 0; n < 20 && o_ins_ready !== 1'b1; n++) @(negedge I_CLK);
    if (o_ins_ready !== 1'b1) begin
      miscompares++;
      tally_and_finish();
    end
    @(posedge I_CLK);
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------------------
  task automatic add_case(input logic [7:0] src, input logic [7:0] dst);
    logic [11:0] da;
    logic [8:0]  sum;
    int          n;
    da = map(dst);
    sum = {1'b0, pm.mem[map(src)]} + {1'b0, pm.mem[da]};
    send(8'h55);
    send(ofd_pkg::OFD_OPC_ADD);
    send(src);
    send(dst);
    @(negedge I_CLK);
    i_ins_valid = 1'b0;
    check("ready while busy", 16'(o_ins_ready), 16'h0000);
    n = 0;
    while (o_add_done !== 1'b1 && n < 20) begin
      @(negedge I_CLK);
      n++;
    end
    if (n == 20) begin
      miscompares++;
      tally_and_finish();
    end
    check("done delay", 16'(n), 16'h0003);
    check("write strobe", 16'(o_rf.wr), 16'h0001);
    check("write address", 16'(o_rf.addr), 16'(da));
    check("sum", 16'(o_rf.wdata), 16'(sum[7:0]));
    check("carry", 16'(o_add_carry), 16'(sum[8]));
    @(negedge I_CLK);
    check("stored", 16'(pm.mem[da]), 16'(sum[7:0]));
    check("done pulse", 16'(o_add_done), 16'h0000);
    check("ready after add", 16'(o_ins_ready), 16'h0001);
  endtask

  task automatic fld(input ofd_pkg::ofd_kind_t k, input logic [7:0] b0, input logic [7:0] b1,
                     input logic [15:0] exp, input logic err, input logic [1:0] w);
    @(negedge I_CLK);
    i_fld = '{valid: 1'b1, kind: k, b0: b0, b1: b1, next_pc: 16'h1000};
    @(negedge I_CLK);
    check("field valid", 16'(o_fld.valid), 16'h0001);
    check("field value", o_fld.value, exp);
    check("field error", 16'(o_fld.err), 16'(err));
    if (w[1]) check("working", 16'(o_fld.working), 16'(w[0]));
  endtask

  // ----------------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------------
  initial begin
    repeat (10) @(negedge I_CLK);
    I_RST = 1'b0;
    add_case(8'h08, 8'h43);
    add_case(8'hE8, 8'hFF);
    add_case(8'hFE, 8'hE3);
    fld(ofd_pkg::OFD_K_REG8, 8'hE8, 8'h00, 16'h0128, 1'b0, 2'b11);
    fld(ofd_pkg::OFD_K_REG8, 8'hFF, 8'h00, 16'h00FF, 1'b0, 2'b10);
    fld(ofd_pkg::OFD_K_BIT, 8'hFF, 8'h00, 16'h0007, 1'b0, 2'b00);
    fld(ofd_pkg::OFD_K_POL, 8'hFE, 8'h00, 16'h0000, 1'b0, 2'b00);
    fld(ofd_pkg::OFD_K_POL, 8'h01, 8'h00, 16'h0001, 1'b0, 2'b00);
    fld(ofd_pkg::OFD_K_LIT, 8'hFF, 8'h00, 16'h00FF, 1'b0, 2'b00);
    fld(ofd_pkg::OFD_K_VEC, 8'hC3, 8'h00, 16'h00C3, 1'b0, 2'b00);
    fld(ofd_pkg::OFD_K_IND, 8'hA5, 8'h00, 16'h00A5, 1'b0, 2'b00);
    fld(ofd_pkg::OFD_K_EXT12, 8'hAF, 8'hFF, 16'h0FFF, 1'b0, 2'b00);
    fld(ofd_pkg::OFD_K_DIRECT, 8'hFF, 8'hFE, 16'hFFFE, 1'b0, 2'b00);
    fld(ofd_pkg::OFD_K_WPAIR, 8'h0E, 8'h00, 16'h000E, 1'b0, 2'b11);
    fld(ofd_pkg::OFD_K_WPAIR, 8'h03, 8'h00, 16'h0002, 1'b1, 2'b11);
    fld(ofd_pkg::OFD_K_RPAIR, 8'hFE, 8'h00, 16'h00FE, 1'b0, 2'b00);
    fld(ofd_pkg::OFD_K_RPAIR, 8'h11, 8'h00, 16'h0010, 1'b1, 2'b00);
    fld(ofd_pkg::OFD_K_REL, 8'h80, 8'h00, 16'h0F80, 1'b0, 2'b00);
    fld(ofd_pkg::OFD_K_REL, 8'h7F, 8'h00, 16'h107F, 1'b0, 2'b00);
    fld(ofd_pkg::OFD_K_IDX, 8'h80, 8'h10, 16'hFF90, 1'b0, 2'b00);
    fld(ofd_pkg::OFD_K_IDX, 8'h7F, 8'hFF, 16'h017E, 1'b0, 2'b00);
    @(negedge I_CLK);
    i_fld.valid = 1'b0;
    @(negedge I_CLK);
    check("field idle", 16'(o_fld.valid), 16'h0000);
    tally_and_finish();
  end
endmodule

`default_nettype wire
